// File: core/pds_supervisor.sv
`timescale 1ns/1ps
`include "pds_cfg.svh"
// Contract
// - ramp reference to new target in 25 mV steps, 50 mV on rail 0 and LDOs.
// - same ramp when a target register is rewritten without mode change.
// - ramp step rate is a programmable division of the switching clock.
// - bucks run forced pwm while their reference ramps either way.
// - LDO discharge load on while its reference ramps down.
// - power good output frozen while its channel ramps.
// - perf request pin reads as zero unless perf_pin_unmask set.
// - restarts keep unmask and perf levels; perf entered at reset release.
// - unprogrammed perf level falls back to the active level.
// - low power request with hold and no perf wins; later perf ignored.
// - perf first keeps perf mode; host must drop perf for low power.
// - rail 0 hysteretic mode only when enabled and headroom is low.
// - thermal shutdown stops all rails, resets host, flags interrupt.
// - after shutdown clears, wait 100 ms then restart on its own.
// - thermal warning only raises the interrupt flag.
// - foldback when high side limit hits with feedback under 500 mV.
// - every high side event on an enabled buck ends on-time and bumps a 4-bit counter that holds at 15.
// - counter at end of count with power good low trips hiccup.
// - hiccup without per-channel enable stops all, resets, restarts after 100 ms.
// - hiccup with per-channel enable stops that buck only; sequence rail resets host.
// - hiccup rail off three soft starts; reset released after delay.
// - overcurrent counter clears after 15 clean turn-on pulses in a row.
module pds_supervisor
  import pds_pkg::*;
#(
  parameter int MS_CYCLES = `PDS_MS_CYC
)
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // register port
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // host pins
  input wire logic i_perf_request_pin,
  input wire logic i_low_power_request_pin,
  input wire logic i_power_hold_pin,
  input wire logic i_start_request_n,
  output logic o_reset_out_n,
  output logic o_irq_out_n,
  // regulator channels
  input wire pds_ana_t i_ana,
  output pds_ctl_t o_ctl,
  output pds_vset_t o_vref,
  output logic [5:0] o_power_good
);
  logic [3:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_ff;
  logic [7:0] sys_ff, div_ff, rdly_ff, ramp_cnt_ff, sup_cnt_ff, nxt_sup_cnt;
  logic [3:0] hcp_ff, hic_w, trig_w, nxt_fold;
  logic [2:0] mask_ff, flag_ff, nxt_flag, flag_set;
  logic [5:0] seq_ff, prf_set_ff, ramping_w, nxt_pg;
  logic [14:0] ms_cnt_ff;
  logic ms_tick_ff, ramp_tick, twarn_d_ff, perf_i, lp_c, hold_c, seq_ok;
  logic run_on, glob_hic;
  logic [7:0] vact_ff [6];
  logic [7:0] vprf_ff [6];
  logic [7:0] vlp_ff [6];
  logic [7:0] tgt_w [6];
  logic [7:0] rd_mux;
  pds_vset_t nxt_vref;
  pds_sup_t sup_ff, nxt_sup;
  pds_mode_t mode_ff, nxt_mode;

  // three-stage pin sync; a change counts once stages two and three agree
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      pin_s1_ff <= `PDS_PIN_RST;
      pin_s2_ff <= `PDS_PIN_RST;
      pin_s3_ff <= `PDS_PIN_RST;
      pin_ff <= `PDS_PIN_RST;
    end
    else
    begin
      pin_s1_ff <= {i_start_request_n, i_power_hold_pin, i_low_power_request_pin,
                    i_perf_request_pin};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ff <= (pin_s3_ff & ~(pin_s2_ff ^ pin_s3_ff)) | (pin_ff & (pin_s2_ff ^ pin_s3_ff));
    end
  end

  assign perf_i = pin_ff[0] & sys_ff[`PDS_SYS_UNMASK];
  assign lp_c = pin_ff[1];
  assign hold_c = pin_ff[2];

  // configuration; only i_srst clears it, fault restarts leave it alone
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      sys_ff <= `PDS_SYS_RST;
      hcp_ff <= `PDS_HCP_RST;
      mask_ff <= `PDS_MASK_RST;
      div_ff <= `PDS_DIV_RST;
      rdly_ff <= `PDS_RDLY_RST;
      seq_ff <= `PDS_SEQ_RST;
    end
    else if (i_wr)
    begin
      if (i_addr == `PDS_A_SYS) sys_ff <= i_wdata;
      if (i_addr == `PDS_A_HCP) hcp_ff <= i_wdata[3:0];
      if (i_addr == `PDS_A_MASK) mask_ff <= i_wdata[2:0];
      if (i_addr == `PDS_A_DIV) div_ff <= i_wdata;
      if (i_addr == `PDS_A_RDLY) rdly_ff <= i_wdata;
      if (i_addr == `PDS_A_SEQ) seq_ff <= i_wdata[5:0];
    end
  end

  // sticky fault flags, write one to clear; a new event beats the clear
  assign nxt_flag = (flag_ff & ~((i_wr && i_addr == `PDS_A_FLAG) ? i_wdata[2:0] : 3'h0))
                    | flag_set;
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      flag_ff <= 3'h0;
      twarn_d_ff <= 1'b0;
      o_irq_out_n <= 1'b1;
    end
    else
    begin
      flag_ff <= nxt_flag;
      twarn_d_ff <= i_ana.twarn;
      o_irq_out_n <= ~|(nxt_flag & ~mask_ff);
    end
  end

  // millisecond and ramp-step timebases, both from the switching clock
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      ms_cnt_ff <= 15'h0000;
      ms_tick_ff <= 1'b0;
      ramp_cnt_ff <= 8'h00;
    end
    else
    begin
      ms_tick_ff <= (ms_cnt_ff == 15'(MS_CYCLES - 1));
      ms_cnt_ff <= (ms_cnt_ff == 15'(MS_CYCLES - 1)) ? 15'h0000 : ms_cnt_ff + 15'h0001;
      ramp_cnt_ff <= ramp_tick ? 8'h00 : ramp_cnt_ff + 8'h01;
    end
  end
  assign ramp_tick = (ramp_cnt_ff >= div_ff);

  // supervisor: start-up, run, thermal stop, restart wait
  assign seq_ok = (&(~seq_ff | i_ana.pg_raw)) && !(|(hic_w & seq_ff[3:0]));
  assign glob_hic = |(trig_w & ~hcp_ff);
  always_comb
  begin
    nxt_sup = sup_ff;
    nxt_sup_cnt = sup_cnt_ff;
    unique case (sup_ff)
      SUP_IDLE:
      begin
        nxt_sup_cnt = 8'h00;
        if (!pin_ff[3] || hold_c) nxt_sup = SUP_START;
      end
      SUP_START:
      begin
        if (!seq_ok) nxt_sup_cnt = 8'h00;
        else if (ms_tick_ff)
        begin
          if (sup_cnt_ff >= rdly_ff) nxt_sup = SUP_RUN;
          else nxt_sup_cnt = sup_cnt_ff + 8'h01;
        end
      end
      SUP_RUN:
      begin
        nxt_sup_cnt = 8'h00;
        if (|(hic_w & seq_ff[3:0])) nxt_sup = SUP_START;
      end
      SUP_TSD:
      begin
        nxt_sup_cnt = 8'h00;
        if (!i_ana.tsd) nxt_sup = SUP_WAIT;
      end
      SUP_WAIT:
      begin
        if (ms_tick_ff)
        begin
          if (sup_cnt_ff == `PDS_RESTART_MS - 8'h01)
          begin
            nxt_sup = SUP_START;
            nxt_sup_cnt = 8'h00;
          end
          else nxt_sup_cnt = sup_cnt_ff + 8'h01;
        end
      end
      default:
      begin
        nxt_sup = SUP_IDLE;
        nxt_sup_cnt = 8'h00;
      end
    endcase
    if (sup_ff != SUP_IDLE && glob_hic)
    begin
      nxt_sup = SUP_WAIT;
      nxt_sup_cnt = 8'h00;
    end
    if (sup_ff != SUP_IDLE && i_ana.tsd)
    begin
      nxt_sup = SUP_TSD;
      nxt_sup_cnt = 8'h00;
    end
  end
  assign run_on = (nxt_sup == SUP_START) || (nxt_sup == SUP_RUN);

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      sup_ff <= SUP_IDLE;
      sup_cnt_ff <= 8'h00;
      o_reset_out_n <= 1'b0;
    end
    else
    begin
      sup_ff <= nxt_sup;
      sup_cnt_ff <= nxt_sup_cnt;
      o_reset_out_n <= (nxt_sup == SUP_RUN);
    end
  end

  // irq events: thermal stop, thermal warning, any global hiccup or a local hiccup on a sequence rail
  assign flag_set = {glob_hic || |(trig_w & hcp_ff & seq_ff[3:0]),
                     i_ana.twarn & ~twarn_d_ff,
                     (nxt_sup == SUP_TSD) && (sup_ff != SUP_TSD)};

  // power mode; held at active until reset_out_n is released
  always_comb
  begin
    nxt_mode = mode_ff;
    if (sup_ff != SUP_RUN || !o_reset_out_n) nxt_mode = MD_ACT;
    else
    begin
      unique case (mode_ff)
        MD_ACT:
        begin
          if (perf_i) nxt_mode = MD_PERF;
          else if (lp_c && hold_c) nxt_mode = MD_LOWP;
        end
        MD_PERF:
        begin
          if (!perf_i) nxt_mode = (lp_c && hold_c) ? MD_LOWP : MD_ACT;
        end
        MD_LOWP:
        begin
          if (!lp_c) nxt_mode = perf_i ? MD_PERF : MD_ACT;
        end
        default: nxt_mode = MD_ACT;
      endcase
    end
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_srst) mode_ff <= MD_ACT;
    else mode_ff <= nxt_mode;
  end

  genvar g;
  // per-rail targets and reference ramp
  for (g = 0; g < 6; g++)
  begin : g_rail
    localparam logic [7:0] STEP = (g == 0 || g >= 4) ? `PDS_STEP_BIG : `PDS_STEP_SMALL;
    always_ff @(posedge i_mclk)
    begin
      if (i_srst)
      begin
        vact_ff[g] <= `PDS_VACT_RST;
        vprf_ff[g] <= `PDS_VACT_RST;
        vlp_ff[g] <= `PDS_VLP_RST;
        prf_set_ff[g] <= 1'b0;
      end
      else if (i_wr)
      begin
        if (i_addr == `PDS_A_VACT + 6'(g)) vact_ff[g] <= i_wdata;
        if (i_addr == `PDS_A_VLP + 6'(g)) vlp_ff[g] <= i_wdata;
        if (i_addr == `PDS_A_VPRF + 6'(g))
        begin
          vprf_ff[g] <= i_wdata;
          prf_set_ff[g] <= 1'b1;
        end
      end
    end
    assign tgt_w[g] = (mode_ff == MD_PERF) ? (prf_set_ff[g] ? vprf_ff[g] : vact_ff[g])
                    : (mode_ff == MD_LOWP) ? vlp_ff[g] : vact_ff[g];
    assign ramping_w[g] = o_ctl.en[g] && (o_vref[g] != tgt_w[g]);
    // off rails park at zero so a re-enable is a soft start ramp
    always_comb
    begin
      nxt_vref[g] = o_vref[g];
      if (!o_ctl.en[g]) nxt_vref[g] = 8'h00;
      else if (ramp_tick && o_vref[g] < tgt_w[g])
        nxt_vref[g] = (tgt_w[g] - o_vref[g] > STEP) ? o_vref[g] + STEP : tgt_w[g];
      else if (ramp_tick && o_vref[g] > tgt_w[g])
        nxt_vref[g] = (o_vref[g] - tgt_w[g] > STEP) ? o_vref[g] - STEP : tgt_w[g];
    end
    assign nxt_pg[g] = ramping_w[g] ? o_power_good[g] : i_ana.pg_raw[g];
  end

  // per-buck overcurrent filter and hiccup
  for (g = 0; g < 4; g++)
  begin : g_buck
    logic [3:0] oc_cnt_ff, cln_cnt_ff;
    logic [7:0] hoff_cnt_ff;
    logic hic_ff;
    assign trig_w[g] = o_ctl.en[g] && oc_cnt_ff == `PDS_OC_EOC && !i_ana.pg_raw[g];
    assign hic_w[g] = hic_ff;
    always_ff @(posedge i_mclk)
    begin
      if (i_srst || !o_ctl.en[g])
      begin
        oc_cnt_ff <= 4'h0;
        cln_cnt_ff <= 4'h0;
      end
      else if (i_ana.high_side_overcurrent[g])
      begin
        if (oc_cnt_ff != `PDS_OC_EOC) oc_cnt_ff <= oc_cnt_ff + 4'h1;
        cln_cnt_ff <= 4'h0;
      end
      else if (i_ana.hs_on[g])
      begin
        if (cln_cnt_ff == `PDS_CLN_LAST)
        begin
          oc_cnt_ff <= 4'h0;
          cln_cnt_ff <= 4'h0;
        end
        else cln_cnt_ff <= cln_cnt_ff + 4'h1;
      end
    end
    // local hiccup off time counted in ms; a global stop drops it
    always_ff @(posedge i_mclk)
    begin
      if (i_srst || !run_on)
      begin
        hic_ff <= 1'b0;
        hoff_cnt_ff <= 8'h00;
      end
      else if (!hic_ff)
      begin
        hic_ff <= trig_w[g] && hcp_ff[g];
        hoff_cnt_ff <= 8'h00;
      end
      else if (ms_tick_ff)
      begin
        if (hoff_cnt_ff == `PDS_HOFF_MS - 8'h01) hic_ff <= 1'b0;
        hoff_cnt_ff <= hoff_cnt_ff + 8'h01;
      end
    end
    assign nxt_fold[g] = (i_ana.high_side_overcurrent[g] && i_ana.fb_low[g])
                       || (o_ctl.foldback[g] && i_ana.fb_low[g]);
  end

  // channel outputs
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_ctl <= '0;
      o_vref <= '0;
      o_power_good <= 6'h00;
    end
    else
    begin
      o_ctl.en <= {6{run_on}} & {2'b11, ~(hic_w | (trig_w & hcp_ff))};
      o_ctl.forced_pwm <= ramping_w[3:0];
      o_ctl.dischg <= ramping_w[5:4] & {o_vref[5] > tgt_w[5], o_vref[4] > tgt_w[4]};
      o_ctl.foldback <= nxt_fold;
      o_ctl.ontime_end <= i_ana.high_side_overcurrent & o_ctl.en[3:0];
      // analog keeps the 2.9 % band; logic only gates entry on the hyst bit, rail 0 enable, no ramp and low headroom
      o_ctl.hyst <= sys_ff[`PDS_SYS_HYST] && i_ana.vdiff_low && o_ctl.en[0]
                    && !ramping_w[0];
      o_vref <= nxt_vref;
      o_power_good <= nxt_pg;
    end
  end

  // read port: data only in the cycle after the strobe
  always_comb
  begin
    rd_mux = 8'h00;
    if (i_addr[2:0] < 3'h6)
    begin
      if (i_addr[5:3] == 3'(`PDS_A_VACT >> 3)) rd_mux = vact_ff[i_addr[2:0]];
      if (i_addr[5:3] == 3'(`PDS_A_VPRF >> 3)) rd_mux = vprf_ff[i_addr[2:0]];
      if (i_addr[5:3] == 3'(`PDS_A_VLP >> 3)) rd_mux = vlp_ff[i_addr[2:0]];
      if (i_addr[5:3] == 3'(`PDS_A_VREF >> 3)) rd_mux = o_vref[i_addr[2:0]];
    end
    if (i_addr == `PDS_A_SYS) rd_mux = sys_ff;
    if (i_addr == `PDS_A_HCP) rd_mux = {hic_w, hcp_ff};
    if (i_addr == `PDS_A_MASK) rd_mux = {5'h00, mask_ff};
    if (i_addr == `PDS_A_FLAG) rd_mux = {5'h00, flag_ff};
    if (i_addr == `PDS_A_DIV) rd_mux = div_ff;
    if (i_addr == `PDS_A_RDLY) rd_mux = rdly_ff;
    if (i_addr == `PDS_A_SEQ) rd_mux = {2'h0, seq_ff};
    if (i_addr == `PDS_A_STAT) rd_mux = {1'b0, sup_ff, 2'h0, mode_ff};
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_srst) o_rdata <= 8'h00;
    else o_rdata <= i_rd ? rd_mux : 8'h00;
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);

  sequence s_wait_done;
    sup_ff == SUP_WAIT && ms_tick_ff && sup_cnt_ff == (`PDS_RESTART_MS - 8'h01)
      && !i_ana.tsd && !glob_hic;
  endsequence
  sequence s_clean_15th;
    o_ctl.en[2] && g_buck[2].cln_cnt_ff == `PDS_CLN_LAST && i_ana.hs_on[2] && !i_ana.high_side_overcurrent[2];
  endsequence

  a_perf_masked: assert property (!sys_ff[0] && mode_ff != MD_PERF |=> mode_ff != MD_PERF)
    else $error("perf mode entered while pin masked");
  a_lowp_holds: assert property (mode_ff == MD_LOWP && lp_c && sup_ff == SUP_RUN
      && o_reset_out_n && !i_ana.tsd && !glob_hic |=> mode_ff == MD_LOWP)
    else $error("low power left while request high");
  a_perf_holds: assert property (mode_ff == MD_PERF && perf_i && sup_ff == SUP_RUN
      && o_reset_out_n |=> mode_ff == MD_PERF)
    else $error("perf mode left while perf request high");
  // a fault stop may legally drop the rail mid ramp
  a_ramp_forced_pwm: assert property (ramping_w[1] && run_on && !trig_w[1]
      |=> o_ctl.forced_pwm[1] && o_ctl.en[1])
    else $error("buck not forced pwm during ramp");
  a_pg_frozen: assert property ($past(ramping_w[2]) |-> $stable(o_power_good[2]))
    else $error("power good changed during ramp");
  a_tsd_stop: assert property (i_ana.tsd && sup_ff != SUP_IDLE
      |=> !o_reset_out_n && o_ctl.en == 6'h00 && sup_ff == SUP_TSD)
    else $error("thermal stop did not shut down");
  a_tsd_restart: assert property (s_wait_done |=> sup_ff == SUP_START)
    else $error("restart after wait missing");
  a_oc_count: assert property (o_ctl.en[2] && i_ana.high_side_overcurrent[2] && g_buck[2].oc_cnt_ff < `PDS_OC_EOC
      |=> g_buck[2].oc_cnt_ff == $past(g_buck[2].oc_cnt_ff) + 4'h1)
    else $error("overcurrent event not counted");
  a_oc_clear: assert property (s_clean_15th |=> g_buck[2].oc_cnt_ff == 4'h0)
    else $error("counter not cleared after clean pulses");
  a_hic_off: assert property (trig_w[3] && hcp_ff[3] && !i_ana.tsd
      |=> !o_ctl.en[3] [*2])
    else $error("hiccup channel not turned off");
  a_fold_on: assert property (i_ana.high_side_overcurrent[2] && i_ana.fb_low[2] |=> o_ctl.foldback[2])
    else $error("foldback not entered");
endmodule : pds_supervisor

// File: inc/pds_cfg.svh
`ifndef PDS_CFG_SVH
`define PDS_CFG_SVH
// clock and time bases
`define PDS_CLK_NS 40
`define PDS_MS_NS 1000000
`define PDS_MS_CYC (`PDS_MS_NS / `PDS_CLK_NS)
`define PDS_RESTART_MS 8'h64
`define PDS_SS_MS 8'h02
`define PDS_HOFF_MS (8'h03 * `PDS_SS_MS)
// overcurrent filter
`define PDS_OC_EOC 4'hF
`define PDS_CLN_LAST 4'hE
// reference step in code units of 25 mV
`define PDS_STEP_BIG 8'h02
`define PDS_STEP_SMALL 8'h01
// register offsets
`define PDS_A_SYS 6'h00
`define PDS_A_HCP 6'h01
`define PDS_A_MASK 6'h02
`define PDS_A_FLAG 6'h03
`define PDS_A_DIV 6'h04
`define PDS_A_RDLY 6'h05
`define PDS_A_SEQ 6'h06
`define PDS_A_STAT 6'h07
`define PDS_A_VACT 6'h10
`define PDS_A_VPRF 6'h18
`define PDS_A_VLP 6'h20
`define PDS_A_VREF 6'h28
// field positions
`define PDS_SYS_UNMASK 0
`define PDS_SYS_HYST 1
`define PDS_FLG_TSD 0
`define PDS_FLG_TWARN 1
`define PDS_FLG_OC 2
// reset values
`define PDS_SYS_RST 8'h00
`define PDS_HCP_RST 4'h0
`define PDS_MASK_RST 3'h0
`define PDS_DIV_RST 8'h0F
`define PDS_RDLY_RST 8'h0A
`define PDS_SEQ_RST 6'h3F
`define PDS_VACT_RST 8'h28
`define PDS_VLP_RST 8'h20
`define PDS_PIN_RST 4'h8
`endif

// File: inc/pds_pkg.sv
package pds_pkg;
  typedef enum logic [2:0] {
    SUP_IDLE = 3'b000,
    SUP_START = 3'b001,
    SUP_RUN = 3'b010,
    SUP_TSD = 3'b011,
    SUP_WAIT = 3'b100
  } pds_sup_t;
  typedef enum logic [1:0] {
    MD_ACT = 2'b00,
    MD_PERF = 2'b01,
    MD_LOWP = 2'b10
  } pds_mode_t;
  typedef struct packed {
    logic [3:0] high_side_overcurrent;
    logic [3:0] hs_on;
    logic [3:0] fb_low;
    logic [5:0] pg_raw;
    logic vdiff_low;
    logic tsd;
    logic twarn;
  } pds_ana_t;
  typedef struct packed {
    logic [5:0] en;
    logic [3:0] forced_pwm;
    logic [1:0] dischg;
    logic [3:0] foldback;
    logic [3:0] ontime_end;
    logic hyst;
  } pds_ctl_t;
  typedef logic [5:0][7:0] pds_vset_t;
endpackage : pds_pkg

// File: sim/pds_host_model.sv
`timescale 1ns/1ps
module pds_host_model (
  // clock
  input wire logic i_mclk,
  // supervisor outputs seen by the host
  input wire logic i_reset_out_n,
  input wire logic i_irq_out_n,
  // host request pins
  output logic o_perf_request_pin,
  output logic o_low_power_request_pin,
  output logic o_power_hold_pin,
  output logic o_start_request_n
);
  initial
  begin
    o_perf_request_pin = 1'b0;
    o_low_power_request_pin = 1'b0;
    o_power_hold_pin = 1'b0;
    o_start_request_n = 1'b1;
  end
  // gpio writes land just after an edge, as firmware would make them
  // caller may keep perf high while asking for low power
  task drive(input logic perf, input logic lp, input logic hold);
    @(posedge i_mclk);
    o_perf_request_pin <= perf;
    o_low_power_request_pin <= lp;
    o_power_hold_pin <= hold;
  endtask : drive
endmodule : pds_host_model

// File: sim/tb.sv
`timescale 1ns/1ps
`include "pds_cfg.svh"
module tb;
  import pds_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] rdata;
  logic perf, lp, hold, start_n, rst_n, irq_n;
  logic [3:0] oc = 4'h0;
  logic [3:0] hon = 4'h0;
  logic [3:0] fbl = 4'h0;
  logic [5:0] pgk = 6'h00;
  logic vdl = 1'b0;
  logic tsd = 1'b0;
  logic twn = 1'b0;
  pds_ana_t ana;
  pds_ctl_t ctl;
  pds_vset_t vref;
  logic [5:0] pg;
  logic [7:0] d;
  int n;
  int errors = 0;
  int compares = 0;
  // power good follows enable unless a rail is held low on purpose
  assign ana = {oc, hon, fbl, ctl.en & ~pgk, vdl, tsd, twn};
  always #20 mclk = ~mclk;

  pds_supervisor #(.MS_CYCLES(10)) u_dut (.i_mclk(mclk), .i_srst(srst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_perf_request_pin(perf),
    .i_low_power_request_pin(lp), .i_power_hold_pin(hold), .i_start_request_n(start_n),
    .o_reset_out_n(rst_n), .o_irq_out_n(irq_n), .i_ana(ana), .o_ctl(ctl), .o_vref(vref),
    .o_power_good(pg));
  pds_host_model u_host (.i_mclk(mclk), .i_reset_out_n(rst_n), .i_irq_out_n(irq_n),
    .o_perf_request_pin(perf), .o_low_power_request_pin(lp), .o_power_hold_pin(hold),
    .o_start_request_n(start_n));

  task tally_and_finish;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
  endtask : wr

  task rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    @(negedge mclk);
    v = rdata;
  endtask : rd

  function automatic logic [7:0] stat(input pds_mode_t m);
    return {1'b0, SUP_RUN, 2'b00, m};
  endfunction : stat

  // bounded wait for the host reset level, n counts cycles spent
  task wait_rst(input logic lvl);
    n = 0;
    while (rst_n !== lvl)
    begin
      @(negedge mclk);
      n++;
      if (n > 3000)
      begin
        errors++;
        tally_and_finish();
      end
    end
  endtask : wait_rst

  task burst(input logic sel, input logic [3:0] m, input int cnt);
    repeat (cnt)
    begin
      @(posedge mclk);
      if (sel) hon <= m; else oc <= m;
      @(posedge mclk);
      oc <= 4'h0;
      hon <= 4'h0;
    end
  endtask : burst

  task t_regs;
    logic [5:0] ra [10] = '{`PDS_A_SYS, `PDS_A_HCP, `PDS_A_MASK, `PDS_A_FLAG, `PDS_A_DIV,
      `PDS_A_RDLY, `PDS_A_SEQ, `PDS_A_VACT, `PDS_A_VPRF, 6'h3F};
    logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h0A, 8'h3F, 8'h28, 8'h28, 8'h00};
    chk("reset out", rst_n, 1'b0);
    chk("irq out", irq_n, 1'b1);
    for (int i = 0; i < 10; i++)
    begin
      rd(ra[i], d);
      chk("reg reset", d, rv[i]);
    end
    wr(`PDS_A_DIV, 8'h03);
    wr(`PDS_A_RDLY, 8'h01);
  endtask : t_regs

  task t_start;
    u_host.drive(1'b0, 1'b0, 1'b1);
    wait_rst(1'b1);
    for (int i = 0; i < 300 && vref[1] !== 8'h28; i++) @(negedge mclk);
    for (int r = 0; r < 6; r++) chk("vref act", vref[r], 8'h28);
    rd(`PDS_A_STAT, d);
    chk("stat run", d, stat(MD_ACT));
  endtask : t_start

  // step size, spacing, forced pwm, discharge and frozen power good while ramping
  task t_ramp(input int r, input logic [7:0] tgt, input logic [7:0] step);
    logic [7:0] prev;
    int gap, k;
    wr(`PDS_A_VACT + 6'(r), tgt);
    // drop raw power good only once the ramp is under way
    if (r == 1) pgk[1] <= 1'b1;
    prev = vref[r];
    gap = 0;
    k = 0;
    for (int i = 0; i < 400 && vref[r] !== tgt; i++)
    begin
      @(negedge mclk);
      gap++;
      if (vref[r] !== prev)
      begin
        chk("ramp step", (vref[r] > prev) ? vref[r] - prev : prev - vref[r], step);
        if (k > 0 && vref[r] !== tgt) chk("ramp gap", gap, 4);
        if (k > 0 && r < 4) chk("forced_pwm", ctl.forced_pwm[r], 1'b1);
        if (k > 0 && r > 3) chk("discharge", ctl.dischg[r - 4], 1'b1);
        if (k > 0 && r == 1) chk("pg frozen", pg[1], 1'b1);
        k++;
        gap = 0;
        prev = vref[r];
      end
    end
    chk("ramp end", vref[r], tgt);
    pgk <= 6'h00;
    repeat (3) @(negedge mclk);
    if (r < 4) chk("forced_pwm off", ctl.forced_pwm[r], 1'b0);
  endtask : t_ramp

  task t_modes;
    u_host.drive(1'b1, 1'b0, 1'b1);
    repeat (8) @(negedge mclk);
    rd(`PDS_A_STAT, d);
    chk("perf masked", d, stat(MD_ACT));
    wr(`PDS_A_SYS, 8'h01);
    repeat (8) @(negedge mclk);
    rd(`PDS_A_STAT, d);
    chk("perf mode", d, stat(MD_PERF));
    repeat (200) @(negedge mclk);
    chk("perf default", vref[3], 8'h28);
    wr(`PDS_A_VPRF + 6'h03, 8'h30);
    u_host.drive(1'b1, 1'b1, 1'b1);
    repeat (8) @(negedge mclk);
    rd(`PDS_A_STAT, d);
    chk("perf kept", d, stat(MD_PERF));
    u_host.drive(1'b0, 1'b1, 1'b1);
    repeat (8) @(negedge mclk);
    rd(`PDS_A_STAT, d);
    chk("low power", d, stat(MD_LOWP));
    u_host.drive(1'b1, 1'b1, 1'b1);
    repeat (8) @(negedge mclk);
    rd(`PDS_A_STAT, d);
    chk("perf ignored", d, stat(MD_LOWP));
    u_host.drive(1'b1, 1'b0, 1'b1);
  endtask : t_modes

  task t_warn;
    twn <= 1'b1;
    repeat (4) @(negedge mclk);
    chk("warn irq", irq_n, 1'b0);
    chk("warn no reset", rst_n, 1'b1);
    rd(`PDS_A_FLAG, d);
    chk("warn flag", d, 8'h02);
    twn <= 1'b0;
    wr(`PDS_A_FLAG, 8'h02);
    wr(`PDS_A_MASK, 8'h02);
    twn <= 1'b1;
    repeat (4) @(negedge mclk);
    chk("warn masked", irq_n, 1'b1);
    twn <= 1'b0;
    wr(`PDS_A_FLAG, 8'h02);
    wr(`PDS_A_MASK, 8'h00);
  endtask : t_warn

  task t_tsd;
    @(posedge mclk);
    tsd <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk("tsd reset", rst_n, 1'b0);
    chk("tsd rails", ctl.en, 6'h00);
    chk("tsd irq", irq_n, 1'b0);
    repeat (5) @(posedge mclk);
    tsd <= 1'b0;
    wait_rst(1'b1);
    chk("tsd delay", n >= 1000, 1'b1);
    rd(`PDS_A_STAT, d);
    chk("perf at release", d, stat(MD_PERF));
    rd(`PDS_A_SYS, d);
    chk("unmask kept", d, 8'h01);
    wr(`PDS_A_FLAG, 8'h01);
    u_host.drive(1'b0, 1'b0, 1'b1);
  endtask : t_tsd

  task t_oc;
    pgk[2] <= 1'b1;
    fbl[2] <= 1'b1;
    burst(1'b0, 4'h4, 1);
    @(negedge mclk);
    chk("on-time end", ctl.ontime_end[2], 1'b1);
    chk("foldback", ctl.foldback[2], 1'b1);
    burst(1'b1, 4'h4, 15);
    burst(1'b0, 4'h4, 14);
    repeat (2) @(negedge mclk);
    chk("counter cleared", rst_n, 1'b1);
    burst(1'b0, 4'h4, 1);
    repeat (2) @(negedge mclk);
    chk("hiccup reset", rst_n, 1'b0);
    chk("hiccup all off", ctl.en, 6'h00);
    chk("hiccup irq", irq_n, 1'b0);
    pgk <= 6'h00;
    fbl <= 4'h0;
    wait_rst(1'b1);
    chk("hiccup delay", n >= 1000, 1'b1);
    wr(`PDS_A_FLAG, 8'h04);
  endtask : t_oc

  task t_local;
    wr(`PDS_A_HCP, 8'h08);
    pgk[3] <= 1'b1;
    burst(1'b0, 4'h8, 15);
    // rail drops one edge after the trip, host reset one edge later
    repeat (3) @(negedge mclk);
    chk("local off", ctl.en, 6'h37);
    chk("local reset", rst_n, 1'b0);
    chk("local irq", irq_n, 1'b0);
    pgk <= 6'h00;
    n = 0;
    for (int i = 0; i < 200 && ctl.en[3] !== 1'b1; i++)
    begin
      @(negedge mclk);
      n++;
    end
    // six 10-cycle ms ticks, first tick phase unknown
    chk("hiccup off time", n >= 51 && n <= 60, 1'b1);
    wait_rst(1'b1);
    chk("reset delay", n >= 10, 1'b1);
  endtask : t_local

  task t_hyst;
    wr(`PDS_A_SYS, 8'h02);
    vdl <= 1'b1;
    repeat (4) @(negedge mclk);
    chk("hyst on", ctl.hyst, 1'b1);
    wr(`PDS_A_SYS, 8'h00);
    repeat (4) @(negedge mclk);
    chk("hyst disabled", ctl.hyst, 1'b0);
    wr(`PDS_A_SYS, 8'h02);
    vdl <= 1'b0;
    repeat (4) @(negedge mclk);
    chk("hyst headroom", ctl.hyst, 1'b0);
  endtask : t_hyst

  initial
  begin
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    t_regs();
    t_start();
    t_ramp(1, 8'h2C, 8'h01);
    t_ramp(0, 8'h24, 8'h02);
    t_ramp(4, 8'h1C, 8'h02);
    t_modes();
    t_warn();
    t_tsd();
    t_oc();
    t_local();
    t_hyst();
    tally_and_finish();
  end
endmodule : tb
